// ==== src/sfr_pkg.sv ====
// Constants, tables and types shared by both ends of the register bus.
// Assumes one clock domain; tables are indexed by the register index.
package sfr_pkg;

	// ----------------------------------------------------------------
	// Map shape
	// ----------------------------------------------------------------
	localparam int     NUM_REGS  = 21;
	localparam int     IDX_W     = 5;
	localparam int     BSEL_W    = 3;
	typedef logic [IDX_W-1:0] reg_idx_t;
	typedef logic [7:0]       byte_t;

	typedef struct packed {
		logic     hit;
		reg_idx_t idx;
	} sfr_hit_t;

	// Clock source chosen by the nonvolatile configuration
	typedef enum logic [1:0] {SRC_RC, SRC_WDT, SRC_EXT, SRC_XTAL} clk_src_t;

	// ----------------------------------------------------------------
	// Register table, one entry per index
	// ----------------------------------------------------------------
	localparam byte_t REG_ADDR [NUM_REGS] = '{
		8'h95, 8'h97, 8'ha1, 8'ha2, 8'ha3, 8'hac, 8'had, 8'hbd, 8'hbe, 8'hbf,
		8'hc0, 8'he0, 8'hea, 8'heb, 8'hec, 8'hed, 8'hf0, 8'hf1, 8'hf2, 8'hf3,
		8'h96};
	localparam byte_t REG_RESET [NUM_REGS] = '{
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0e, 8'h00, 8'h00,
		8'h00};
	// Reserved bits
	localparam byte_t REG_RSVD [NUM_REGS] = '{
		8'h00, 8'h00, 8'h1f, 8'h02, 8'h00, 8'hc0, 8'hc0, 8'hfc, 8'h00, 8'h00,
		8'h0f, 8'h00, 8'h00, 8'h00, 8'hf8, 8'hf8, 8'h00, 8'h0e, 8'h00, 8'h00,
		8'hbf};
	// Bits fixed at zero and at one
	localparam byte_t REG_ZERO [NUM_REGS] = '{
		8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00};
	localparam byte_t REG_ONE [NUM_REGS] = '{
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00};
	// Registers reachable per bit
	localparam logic [NUM_REGS-1:0] REG_BITADDR = 21'h010800;

	// Indices used by the logic
	localparam reg_idx_t IDX_CPU_CLOCK_DIVIDER      = 5'd0;
	localparam reg_idx_t IDX_BAUD_CTRL = 5'd7;
	localparam reg_idx_t IDX_TRIM      = 5'd20;

	// Field positions
	localparam int BIT_DIVIDED_CLOCK_OUTPUT_EN = 6;
	localparam int BIT_BRG_EN    = 0;
	localparam int BIT_BRG_SRC   = 1;

	// ----------------------------------------------------------------
	// Host command registers
	// ----------------------------------------------------------------
	localparam logic [2:0] H_TARGET = 3'h0;
	localparam logic [2:0] H_DATA   = 3'h1;
	localparam logic [2:0] H_CTRL   = 3'h2;
	localparam logic [2:0] H_STATUS = 3'h3;
	localparam logic [2:0] H_RESULT = 3'h4;
	localparam int CTRL_WRITE = 0;
	localparam int CTRL_READ  = 1;
	localparam int CTRL_BIT   = 2;
	localparam int ST_BUSY    = 0;
	localparam int ST_REFUSED = 1;
	localparam int ST_DONE    = 2;

	// Address to index lookup
	function automatic sfr_hit_t sfr_lookup(input byte_t a);
		sfr_hit_t r;
		r = '0;
		for (int i = 0; i < NUM_REGS; i++) begin
			if (REG_ADDR[i] == a) begin
				r.hit = 1'b1;
				r.idx = reg_idx_t'(i);
			end
		end
		return r;
	endfunction : sfr_lookup

endpackage : sfr_pkg

// ==== src/sfr_if.sv ====
// Register bus between the processor core and the register bank.
// Assumes one clock; read data stand one cycle after the strobe.
`timescale 1ns/1ns
interface sfr_if (
	input wire logic clk,
	input wire logic reset
);
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic [7:0] bit_addr;
	logic       bit_wdata;
	logic       bit_wr;
	logic       bit_rd;
	logic       bit_rdata;

	modport core (
		input  clk, reset, rdata, bit_rdata,
		output addr, wdata, wr, rd, bit_addr, bit_wdata, bit_wr, bit_rd
	);
	modport dev (
		input  clk, reset, addr, wdata, wr, rd, bit_addr, bit_wdata, bit_wr, bit_rd,
		output rdata, bit_rdata
	);
endinterface : sfr_if

// ==== src/clock_halver.sv ====
// Toggle flip-flop that halves the clock while enabled.
// Assumes clk is the processor clock.
`timescale 1ns/1ns
module clock_halver (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// Control
	input  wire logic enable,
	// Halved clock
	output logic      half_q
);
	// Toggle each cycle, park low when off
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			half_q <= 1'b0;
		else
			half_q <= enable ? ~half_q : 1'b0;
	end
endmodule : clock_halver

// ==== src/sfr_bank.sv ====
// Register bank with per-bit access and the port 3 pin functions.
// Assumes the core on sfr_if keeps to the map; pins and straps are async.
// Assumes port latches share clk and need no synchroniser.
// Pin outputs lag their selection by one flop, so pads never glitch.
`timescale 1ns/1ns
module sfr_bank
	import sfr_pkg::*;
(
	// Register bus
	sfr_if.dev          bus,
	// Clock source straps
	input  wire logic [1:0] clk_src_cfg,
	input  wire logic       rtc_on_crystal,
	input  wire logic       osc_amp_in,
	// Port 3 latches from the port logic
	input  wire logic [1:0] port_out,
	input  wire logic [1:0] port_oe,
	output logic [1:0]      port_in,
	// Port 3 pins
	input  wire logic       port3_bit0_i,
	output logic            port3_bit0_o,
	output logic            port3_bit0_oe,
	input  wire logic       port3_bit1_i,
	output logic            port3_bit1_o,
	output logic            port3_bit1_oe,
	// Register fields to the peripherals
	output logic [7:0]      cpu_clock_divider,
	output logic            baud_generator_enable,
	output logic            baud_source_select
);
	wire clk   = bus.clk;
	wire reset = bus.reset;

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	byte_t    regs_q [NUM_REGS];
	byte_t    regs_d [NUM_REGS];
	sfr_hit_t byte_hit;
	sfr_hit_t bit_hit;
	wire      bit_ok;
	wire [BSEL_W-1:0] bit_sel;
	byte_t    rd_val;
	logic     bit_val;

	// Address decode
	assign byte_hit = sfr_lookup(bus.addr);
	assign bit_hit  = sfr_lookup({bus.bit_addr[7:BSEL_W], 3'h0});
	assign bit_ok   = bit_hit.hit && REG_BITADDR[bit_hit.idx];
	assign bit_sel  = bus.bit_addr[BSEL_W-1:0];

	// Per-register strobes; unmapped addresses hit none
	wire [NUM_REGS-1:0] byte_we;
	wire [NUM_REGS-1:0] bit_we;
	for (genvar g = 0; g < NUM_REGS; g++) begin : g_we
		assign byte_we[g] = bus.wr && byte_hit.hit && byte_hit.idx == reg_idx_t'(g);
		assign bit_we[g]  = bus.bit_wr && bit_ok && bit_hit.idx == reg_idx_t'(g);
	end

	// Read value with fixed bits forced
	assign rd_val = byte_hit.hit ?
		((regs_q[byte_hit.idx] & ~REG_ZERO[byte_hit.idx])
		| REG_ONE[byte_hit.idx]) : 8'h00;
	assign bit_val = bit_ok ? regs_q[bit_hit.idx][bit_sel] : 1'b0;

	// Next state of every register
	always_comb begin
		for (int i = 0; i < NUM_REGS; i++) begin
			regs_d[i] = regs_q[i];
			if (byte_we[i])
				regs_d[i] = bus.wdata;
			if (bit_we[i])
				regs_d[i][bit_sel] = bus.bit_wdata;
			// Fixed bits forced last, after either write path
			regs_d[i] = (regs_d[i] & ~REG_ZERO[i]) | REG_ONE[i];
		end
	end

	// Storage, reserved bits kept as written
	// Software reads reserved bits back as zero once written; the core end clears them
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < NUM_REGS; i++)
				regs_q[i] <= REG_RESET[i];
		end else begin
			for (int i = 0; i < NUM_REGS; i++)
				regs_q[i] <= regs_d[i];
		end
	end

	// Read data, one cycle after the strobe
	// Zero outside read cycles keeps the return bus quiet
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bus.rdata     <= 8'h00;
			bus.bit_rdata <= 1'b0;
		end else begin
			bus.rdata     <= bus.rd ? rd_val : 8'h00;
			bus.bit_rdata <= bus.bit_rd ? bit_val : 1'b0;
		end
	end

	// Fields to peripherals
	assign cpu_clock_divider     = regs_q[IDX_CPU_CLOCK_DIVIDER];
	assign baud_generator_enable = regs_q[IDX_BAUD_CTRL][BIT_BRG_EN];
	assign baud_source_select    = regs_q[IDX_BAUD_CTRL][BIT_BRG_SRC];

	// Trim register: only the clock-out enable is used
	wire   divided_clock_output_en_bit         = regs_q[IDX_TRIM][BIT_DIVIDED_CLOCK_OUTPUT_EN];

	// ----------------------------------------------------------------
	// Synchronisers for straps and pins
	// ----------------------------------------------------------------
	localparam int SYNC_W = 6;
	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;
	wire  [SYNC_W-1:0] async_in = {
		clk_src_cfg,
		rtc_on_crystal,
		osc_amp_in,
		port3_bit1_i,
		port3_bit0_i
	};

	// Two flops before any use
	// Only sync2_q feeds logic; sync1_q may be metastable
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= async_in;
			sync2_q <= sync1_q;
		end
	end

	clk_src_t src;
	wire      rtc_xtal = sync2_q[3];
	wire      amp_s    = sync2_q[2];
	assign src     = clk_src_t'(sync2_q[5:4]);
	assign port_in = sync2_q[1:0];

	// ----------------------------------------------------------------
	// Pin functions
	// ----------------------------------------------------------------
	// Any crystal use refuses clock out and the port on bit 1
	wire divided_clock_output_ok   = (src != SRC_XTAL) && !rtc_xtal;
	wire divided_clock_output_on   = divided_clock_output_en_bit && divided_clock_output_ok;
	wire crystal_osc = (src == SRC_XTAL) || rtc_xtal;
	wire bit1_gpio   = (src == SRC_RC || src == SRC_WDT) && !rtc_xtal;
	wire p1_o_d      = bit1_gpio && port_out[1];
	wire p1_oe_d     = bit1_gpio && port_oe[1];
	wire half_clk;

	// Halved processor clock
	// Parks low while off, so the pin never sticks high
	clock_halver u_half (
		.clk    (clk),
		.reset  (reset),
		.enable (divided_clock_output_on),
		.half_q (half_clk)
	);

	logic p0_o_d;
	logic p0_oe_d;

	// Bit 0 selection: crystal, then halved clock, then port
	// Crystal first: nothing may fight the amplifier
	always_comb begin
		if (crystal_osc) begin
			p0_o_d  = amp_s;
			p0_oe_d = 1'b1;
		end else if (divided_clock_output_on) begin
			p0_o_d  = half_clk;
			p0_oe_d = 1'b1;
		end else begin
			p0_o_d  = port_out[0];
			p0_oe_d = port_oe[0];
		end
	end

	// Registered pin drivers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			port3_bit0_o  <= 1'b0;
			port3_bit0_oe <= 1'b0;
			port3_bit1_o  <= 1'b0;
			port3_bit1_oe <= 1'b0;
		end else begin
			port3_bit0_o  <= p0_o_d;
			port3_bit0_oe <= p0_oe_d;
			port3_bit1_o  <= p1_o_d;
			port3_bit1_oe <= p1_oe_d;
		end
	end

endmodule : sfr_bank

// ==== src/sfr_core_master.sv ====
// Core end: turns software commands into register bus cycles.
// Assumes software uses the plain command port; bus answers in one cycle.
`timescale 1ns/1ns
module sfr_core_master
	import sfr_pkg::*;
(
	// Register bus
	sfr_if.core         bus,
	// Software command port
	input  wire logic [2:0] sw_addr,
	input  wire logic [7:0] sw_wdata,
	input  wire logic       sw_wr,
	input  wire logic       sw_rd,
	output logic [7:0]      sw_rdata
);
	wire clk   = bus.clk;
	wire reset = bus.reset;

	typedef enum {ST_IDLE, ST_ISSUE, ST_CAPTURE} state_t;
	state_t     state_q;
	logic [7:0] target_q;
	logic [7:0] data_q;
	logic [2:0] op_q;
	logic [7:0] result_q;
	logic       refused_q;
	logic       done_q;

	// Command decode and refusal of undefined targets
	sfr_hit_t   thit;
	sfr_hit_t   bhit;
	assign thit = sfr_lookup(target_q);
	assign bhit = sfr_lookup({target_q[7:BSEL_W], 3'h0});
	wire launch  = sw_wr && sw_addr == H_CTRL && state_q == ST_IDLE;
	wire bitmode = sw_wdata[CTRL_BIT];
	wire legal   = bitmode ? (bhit.hit && REG_BITADDR[bhit.idx]) : thit.hit;
	wire any_op  = sw_wdata[CTRL_WRITE] || sw_wdata[CTRL_READ];
	wire wmode   = sw_wdata[CTRL_WRITE];
	wire is_read = op_q[CTRL_READ] && !op_q[CTRL_WRITE];

	// Masked write data, reserved and fixed bits forced
	wire [7:0] wmask = (data_q & ~REG_RSVD[thit.idx] & ~REG_ZERO[thit.idx])
		| REG_ONE[thit.idx];

	// Sequencer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q   <= ST_IDLE;
			target_q  <= 8'h00;
			data_q    <= 8'h00;
			op_q      <= 3'h0;
			result_q  <= 8'h00;
			refused_q <= 1'b0;
			done_q    <= 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (sw_wr && sw_addr == H_TARGET)
						target_q <= sw_wdata;
					if (sw_wr && sw_addr == H_DATA)
						data_q <= sw_wdata;
					if (launch && any_op) begin
						op_q      <= 3'(sw_wdata);
						refused_q <= !legal;
						done_q    <= 1'b0;
						if (legal)
							state_q <= ST_ISSUE;
						if (legal && wmode && !bitmode)
							data_q <= wmask;
					end
				end
				ST_ISSUE: begin
					state_q <= is_read ? ST_CAPTURE : ST_IDLE;
					done_q  <= !is_read;
				end
				ST_CAPTURE: begin
					result_q <= op_q[CTRL_BIT] ? {7'h00, bus.bit_rdata} : bus.rdata;
					done_q   <= 1'b1;
					state_q  <= ST_IDLE;
				end
			endcase
		end
	end

	// Bus strobes during the issue cycle only
	wire issue = state_q == ST_ISSUE;
	assign bus.addr      = target_q;
	assign bus.wdata     = data_q;
	assign bus.bit_addr  = target_q;
	assign bus.bit_wdata = data_q[0];
	assign bus.wr        = issue && op_q[CTRL_WRITE] && !op_q[CTRL_BIT];
	assign bus.rd        = issue && is_read && !op_q[CTRL_BIT];
	assign bus.bit_wr    = issue && op_q[CTRL_WRITE] && op_q[CTRL_BIT];
	assign bus.bit_rd    = issue && is_read && op_q[CTRL_BIT];

	// Software read port, data one cycle after the strobe
	logic [7:0] sw_sel;
	always_comb begin
		unique case (sw_addr)
			H_TARGET: sw_sel = target_q;
			H_DATA:   sw_sel = data_q;
			H_CTRL:   sw_sel = {5'h00, op_q};
			H_STATUS: sw_sel = {5'h00, done_q, refused_q, state_q != ST_IDLE};
			H_RESULT: sw_sel = result_q;
			default:  sw_sel = 8'h00;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			sw_rdata <= 8'h00;
		else
			sw_rdata <= sw_rd ? sw_sel : 8'h00;
	end

endmodule : sfr_core_master

// ==== dv/sfr_bank_assertions.sv ====
// Concurrent checks on the register bus between core and bank.
// Assumes one clock, reset active high, strobes made by the core end.
`timescale 1ns/1ns
module sfr_bank_assertions (
	// Clock and reset
	input wire logic       clk,
	input wire logic       reset,
	// Register bus
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic [7:0] bit_addr,
	input wire logic       bit_wdata,
	input wire logic       bit_wr,
	input wire logic       bit_rd,
	input wire logic       bit_rdata
);
	// ----------------------------------------------------------------
	// Shadows of divider and accumulator, and the eeprom control first-write flag
	// ----------------------------------------------------------------
	logic [7:0] div_q;
	logic [7:0] acc_q;
	logic [2:0] bidx_q;
	logic       f1_new_q;

	// Track what software last stored
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			div_q    <= 8'h00;
			acc_q    <= 8'h00;
			bidx_q   <= 3'h0;
			f1_new_q <= 1'b1;
		end else begin
			bidx_q <= bit_addr[2:0];
			if (wr && addr == 8'h95) div_q <= wdata;
			if (wr && addr == 8'he0) acc_q <= wdata;
			if (bit_wr && bit_addr[7:3] == 5'h1c) acc_q[bit_addr[2:0]] <= bit_wdata;
			if (wr && addr == 8'hf1) f1_new_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	sequence div_rd_s;
		rd && addr == 8'h95;
	endsequence
	sequence acc_bit_rd_s;
		bit_rd && bit_addr[7:3] == 5'h1c;
	endsequence

	idle_rdata_zero_a: assert property (!rd |=> rdata == 8'h00)
		else $error("read data outside read cycle");
	idle_bit_zero_a: assert property (!bit_rd |=> !bit_rdata)
		else $error("bit read data outside read cycle");
	single_strobe_a: assert property (!(wr && rd))
		else $error("write and read strobes together");
	divider_readback_a: assert property (div_rd_s |=> rdata == div_q)
		else $error("divider read differs from last write");
	acc_byte_read_a: assert property (rd && addr == 8'he0 |=> rdata == acc_q)
		else $error("accumulator byte read wrong");
	acc_bit_read_a: assert property (acc_bit_rd_s |=> bit_rdata == acc_q[bidx_q])
		else $error("accumulator bit read wrong");
	eeprom_reset_a: assert property (rd && addr == 8'hf1 && f1_new_q |=> rdata == 8'h0e)
		else $error("eeprom control reset value wrong");
	fixed_zero_a: assert property (rd && addr == 8'ha2 |=> !rdata[2])
		else $error("fixed zero bit reads one");
	baud_mask_a: assert property (wr && addr == 8'hbd |-> wdata[7:2] == 6'h00)
		else $error("reserved baud bits written nonzero");
endmodule : sfr_bank_assertions

// ==== dv/sfr_map_and_clock_out_pin_bench.sv ====
// Bench joining core master and register bank over the register bus.
// Assumes 20 MHz clock; pins pulled up when nobody drives them.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin num_errors++; \
	$display("BAD %s exp %h got %h", nm, ex, got); end end
module sfr_map_and_clock_out_pin_bench
	import sfr_pkg::*;
;
	typedef struct {byte_t tgt; byte_t dat; byte_t exp;} row_t;
	row_t rows [8] = '{'{8'h95, 8'ha5, 8'ha5}, '{8'hbd, 8'hff, 8'h03}, '{8'ha2, 8'hff, 8'hf9},
		'{8'he0, 8'h3c, 8'h3c}, '{8'hf0, 8'hc3, 8'hc3}, '{8'hac, 8'hff, 8'h3f},
		'{8'hc0, 8'hff, 8'hf0}, '{8'hf1, 8'hff, 8'hf1}};
	logic       clk = 1'b0;
	logic       reset = 1'b1;
	logic [2:0] sw_addr = 3'h0;
	byte_t      sw_wdata = 8'h00;
	byte_t      sw_rdata;
	logic       sw_wr = 1'b0;
	logic       sw_rd = 1'b0;
	logic [1:0] clk_src_cfg = 2'h0;
	logic       rtc_on_crystal = 1'b0;
	logic       osc_amp_in = 1'b0;
	logic [1:0] port_out = 2'h0;
	logic [1:0] port_oe = 2'h0;
	logic [1:0] port_in;
	logic       p0_o, p0_oe, p1_o, p1_oe, brg_en, brg_src;
	wire logic  p0_i = p0_oe ? p0_o : 1'b1;
	wire logic  p1_i = p1_oe ? p1_o : 1'b1;
	byte_t      div;
	int         num_errors = 0;
	int         check_count = 0;
	int         cycles = 0;

	always #25 clk = ~clk;

	sfr_if i_sfr_if (.clk(clk), .reset(reset));
	sfr_core_master i_sfr_core_master (.bus(i_sfr_if.core), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
	sfr_bank i_sfr_bank (.bus(i_sfr_if.dev), .clk_src_cfg(clk_src_cfg),
		.rtc_on_crystal(rtc_on_crystal), .osc_amp_in(osc_amp_in), .port_out(port_out),
		.port_oe(port_oe), .port_in(port_in), .port3_bit0_i(p0_i), .port3_bit0_o(p0_o),
		.port3_bit0_oe(p0_oe), .port3_bit1_i(p1_i), .port3_bit1_o(p1_o),
		.port3_bit1_oe(p1_oe), .cpu_clock_divider(div), .baud_generator_enable(brg_en),
		.baud_source_select(brg_src));
	sfr_bank_assertions i_sfr_bank_assertions (.clk(clk), .reset(reset),
		.addr(i_sfr_if.addr), .wdata(i_sfr_if.wdata), .wr(i_sfr_if.wr), .rd(i_sfr_if.rd),
		.rdata(i_sfr_if.rdata), .bit_addr(i_sfr_if.bit_addr), .bit_wdata(i_sfr_if.bit_wdata),
		.bit_wr(i_sfr_if.bit_wr), .bit_rd(i_sfr_if.bit_rd), .bit_rdata(i_sfr_if.bit_rdata));

	// ----------------------------------------------------------------
	// Software port tasks
	// ----------------------------------------------------------------
	task automatic sw_put(input logic [2:0] a, input byte_t d);
		@(posedge clk);
		sw_addr  <= a;
		sw_wdata <= d;
		sw_wr    <= 1'b1;
		@(posedge clk);
		sw_wr <= 1'b0;
	endtask : sw_put

	task automatic sw_get(input logic [2:0] a, output byte_t d);
		@(posedge clk);
		sw_addr <= a;
		sw_rd   <= 1'b1;
		@(posedge clk);
		sw_rd <= 1'b0;
		#1 d = sw_rdata;
	endtask : sw_get

	task automatic sfr_op(input logic [2:0] c, input byte_t t, input byte_t d,
		output byte_t st, output byte_t res);
		sw_put(H_TARGET, t);
		sw_put(H_DATA, d);
		sw_put(H_CTRL, {5'h00, c});
		st = 8'h00;
		for (int n = 0; n < 12 && !(st[ST_DONE] || st[ST_REFUSED]); n++) sw_get(H_STATUS, st);
		sw_get(H_RESULT, res);
	endtask : sfr_op

	task automatic end_of_test();
		if (num_errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test

	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			num_errors++;
			end_of_test();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		byte_t st, res;
		logic  h, xtal;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < NUM_REGS; i++) begin
			sfr_op(3'h2, REG_ADDR[i], 8'h00, st, res);
			`CHK("reset value", REG_RESET[i], res)
		end
		for (int i = 0; i < 8; i++) begin
			sfr_op(3'h1, rows[i].tgt, rows[i].dat, st, res);
			sfr_op(3'h2, rows[i].tgt, 8'h00, st, res);
			`CHK("readback", rows[i].exp, res)
		end
		`CHK("divider", 8'ha5, div)
		`CHK("baud fields", 2'b11, {brg_src, brg_en})
		// Per-bit access to the accumulator
		sfr_op(3'h5, 8'he7, 8'h01, st, res);
		sfr_op(3'h2, 8'he0, 8'h00, st, res);
		`CHK("bit write", 8'hbc, res)
		sfr_op(3'h6, 8'he2, 8'h00, st, res);
		`CHK("bit read", 1'b1, res[0])
		sfr_op(3'h1, 8'h90, 8'h55, st, res);
		`CHK("refused", 2'b01, {st[ST_DONE], st[ST_REFUSED]})
		sw_get(H_TARGET, res);
		`CHK("target kept", 8'h90, res)
		sw_get(H_DATA, res);
		`CHK("data unmasked", 8'h55, res)
		sw_get(H_CTRL, res);
		`CHK("ctrl kept", 8'h01, res)
		// Write and read both set: the write wins
		sfr_op(3'h3, 8'hbe, 8'h5a, st, res);
		sfr_op(3'h2, 8'hbe, 8'h00, st, res);
		`CHK("write wins", 8'h5a, res)
		// Clock output across every source and timer setting
		sfr_op(3'h1, 8'h96, 8'h40, st, res);
		@(posedge clk);
		port_out   <= 2'b10;
		port_oe    <= 2'b10;
		osc_amp_in <= 1'b1;
		for (int c = 0; c < 8; c++) begin
			@(posedge clk);
			clk_src_cfg    <= 2'(c);
			rtc_on_crystal <= c[2];
			osc_amp_in     <= c[0];
			repeat (4) @(posedge clk);
			#1 xtal = (c[1:0] == 2'h3) || c[2];
			h = p0_o;
			`CHK("pin1 port", {c < 2, c < 2}, {p1_oe, p1_o})
			`CHK("pin0 drive", 1'b1, p0_oe)
			if (xtal) `CHK("amp out", c[0], p0_o)
			@(posedge clk);
			#1 `CHK("pin0 level", xtal ? c[0] : ~h, p0_o)
		end
		// Reset in mid-run
		@(posedge clk);
		reset <= 1'b1;
		@(posedge clk);
		#1 `CHK("divider reset", 8'h00, div)
		@(posedge clk);
		reset          <= 1'b0;
		clk_src_cfg    <= 2'h0;
		rtc_on_crystal <= 1'b0;
		port_out       <= 2'b00;
		repeat (4) @(posedge clk);
		#1 `CHK("pin0 released", 1'b0, p0_oe)
		`CHK("pins sensed", 2'b01, port_in)
		sfr_op(3'h2, 8'hf1, 8'h00, st, res);
		`CHK("eeprom reset", 8'h0e, res)
		end_of_test();
	end
endmodule : sfr_map_and_clock_out_pin_bench
